// >>> verification/pdt_rc_model.sv
// integrating network model: counts the high clocks of every pin since clr.
// assumes pin bit 0 is the tuning pin and bits 5..1 the short channels.
`timescale 1ns/100ps
module pdt_rc_model (
	input  wire logic        aclk,
	input  wire logic        clr,
	input  wire logic [5:0]  pin,
	output logic [5:0][31:0] hi_cnt
);
	// a count of high clocks stands in for the filtered voltage
	always_ff @(posedge aclk) begin
		for (int i = 0; i < 6; i++) begin
			if (clr)
				hi_cnt[i] <= 32'h0000_0000;
			else
				hi_cnt[i] <= hi_cnt[i] + {31'h0000_0000, pin[i]};
		end
	end
endmodule // pdt_rc_model

// >>> verification/pdt_top_bench.sv
// self-checking bench: AXI4-Lite master tasks and pin duty measurement.
// assumes pdt_pkg and the integrating model are compiled first.
`timescale 1ns/100ps
module pdt_top_bench;
	logic              aclk, aresetn, clr;
	logic [5:0]        s_axi_awaddr, s_axi_araddr;
	logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic [31:0]       s_axi_wdata, s_axi_rdata;
	logic [3:0]        s_axi_wstrb;
	logic [1:0]        s_axi_bresp, s_axi_rresp, r;
	logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic              s_axi_rvalid, s_axi_rready, tpin;
	logic [4:0]        spin;
	logic [5:0][31:0]  hc;
	logic [31:0]       d;
	int                failures, checks_done;

	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end

	pdt_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .tuning_shared_port_line(tpin),
		.shared_port_line(spin));
	pdt_rc_model rc (.aclk(aclk), .clr(clr), .pin({spin, tpin}), .hi_cnt(hc));

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic end_sim;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// payload held until each channel's own ready is sampled high;
	// bready and rready stay high between transfers
	task automatic wr(input logic [5:0] a, input logic [31:0] v, output logic [1:0] rs);
		int n;
		logic ga, gw;
		n = 0;
		ga = 1'b0;
		gw = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(ga && gw) && n < 100) begin
			@(posedge aclk);
			n++;
			if (!ga && s_axi_awready === 1'b1) begin
				ga = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!gw && s_axi_wready === 1'b1) begin
				gw = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		while (s_axi_bvalid !== 1'b1 && n < 100) begin
			@(posedge aclk);
			n++;
		end
		rs = s_axi_bresp;
		if (n >= 100) begin
			failures++;
			end_sim;
		end
	endtask

	task automatic rd(input logic [5:0] a, output logic [31:0] v, output logic [1:0] rs);
		int n;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
		end while (s_axi_arready !== 1'b1 && n < 100);
		s_axi_arvalid <= 1'b0;
		do begin
			@(posedge aclk);
			n++;
		end while (s_axi_rvalid !== 1'b1 && n < 100);
		v = s_axi_rdata;
		rs = s_axi_rresp;
		if (n >= 100) begin
			failures++;
			end_sim;
		end
	endtask

	task automatic wok(input logic [5:0] a, input logic [31:0] v);
		wr(a, v, r);
		chk("bresp", {30'h0000_0000, pdt_pkg::RESP_OKAY}, {30'h0000_0000, r});
	endtask

	// window of n clocks; the pins are periodic so alignment does not matter
	task automatic measure(input int n);
		clr <= 1'b1;
		@(posedge aclk);
		clr <= 1'b0;
		// one extra edge so the count of the last sample is visible
		repeat (n + 1) @(posedge aclk);
	endtask

	// load coarse then fine, wait for the transfer to settle, check the latch
	task automatic tune_load(input logic [6:0] c, input logic [6:0] f);
		int k;
		wok(pdt_pkg::OFF_COARSE, {25'h000_0000, c});
		wok(pdt_pkg::OFF_FINE, {25'h000_0000, f});
		k = 0;
		do begin
			repeat (50) @(posedge aclk);
			rd(pdt_pkg::OFF_STATUS, d, r);
			k++;
		end while (d[1:0] !== 2'h0 && k < 30);
		if (d[1:0] !== 2'h0) begin
			failures++;
			end_sim;
		end
		chk("work", {18'h0_0000, c, f}, {18'h0_0000, d[21:8]});
		repeat (768) @(posedge aclk);
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_regs;
		rd(pdt_pkg::OFF_CTRL, d, r);
		chk("ctrl_rst", 32'h0000_0040, d);
		rd(6'h28, d, r);
		chk("rresp", {30'h0000_0000, pdt_pkg::RESP_SLVERR}, {30'h0000_0000, r});
		chk("rdata", 32'h0000_0000, d);
		wr(6'h2C, 32'h0000_00ff, r);
		chk("bresp", {30'h0000_0000, pdt_pkg::RESP_SLVERR}, {30'h0000_0000, r});
		wok(pdt_pkg::OFF_STATUS, 32'h0000_ffff);
		rd(pdt_pkg::OFF_STATUS, d, r);
		chk("status_ro", 32'h0000_0000, d);
	endtask

	task automatic t_short;
		logic [5:0] dv[5];
		dv = '{6'h00, 6'h01, 6'h3f, 6'h20, 6'h0a};
		wok(pdt_pkg::OFF_PORT, 32'h0000_0001);
		wok(pdt_pkg::OFF_CTRL, 32'h0000_005f);
		for (int i = 0; i < 5; i++)
			wok(pdt_pkg::OFF_DUTY0 + 6'(4 * i), {26'h000_0000, dv[i]});
		rd(pdt_pkg::OFF_DUTY0 + 6'h10, d, r);
		chk("duty4", 32'h0000_000a, d);
		repeat (200) @(posedge aclk);
		measure(192);
		for (int i = 0; i < 5; i++)
			chk("short_hi", 32'(dv[i]) * 32'h0000_0003, hc[i+1]);
		chk("tun_port", 32'h0000_00c0, hc[0]);
		wok(pdt_pkg::OFF_CTRL, 32'h0000_007f);
		repeat (4) @(posedge aclk);
		measure(192);
		for (int i = 0; i < 5; i++)
			chk("short_inv", 32'h0000_00c0 - 32'(dv[i]) * 32'h0000_0003, hc[i+1]);
	endtask

	task automatic t_port;
		wok(pdt_pkg::OFF_CTRL, 32'h0000_0040);
		wok(pdt_pkg::OFF_PORT, 32'h0000_002a);
		repeat (3) @(posedge aclk);
		chk("port_pins", 32'h0000_002a, {26'h000_0000, spin, tpin});
	endtask

	task automatic t_tune;
		logic [6:0] c, f;
		tune_load(7'h7e, 7'h7f);
		wok(pdt_pkg::OFF_CTRL, 32'h0000_00c0);
		repeat (4) @(posedge aclk);
		measure(384);
		chk("tun_edge", 32'h0000_0003, hc[0]);
		wok(pdt_pkg::OFF_CTRL, 32'h0000_0080);
		repeat (4) @(posedge aclk);
		measure(384);
		chk("tun_inv", 32'h0000_017d, hc[0]);
		c = 7'h1d;
		f = 7'h7a;
		tune_load(c, f);
		wok(pdt_pkg::OFF_CTRL, 32'h0000_00c0);
		repeat (4) @(posedge aclk);
		measure(49152);
		// zero fine bit k adds 2**k pulses per full cycle
		chk("tun_full", 32'h0000_0003 * (32'h0000_0080 * (32'h0000_007f - 32'(c))
			+ 32'h0000_007f - 32'(f)), hc[0]);
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		failures = 0;
		checks_done = 0;
		aresetn = 1'b0;
		clr = 1'b1;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_regs;
		t_short;
		t_port;
		t_tune;
		end_sim;
	end
endmodule // pdt_top_bench

// >>> verilog/pdt_pkg.sv
// package for the pulse-width converter block: register map, field layout,
// reset values, tick timing and the state carrier.
// assumes aclk runs at the crystal rate, so one tick is three clock cycles.
package pdt_pkg;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int          XTAL_PER_TICK      = 3;
	localparam logic [1:0]  TICK_LAST          = 2'(XTAL_PER_TICK - 1);
	localparam int          SHORT_PERIOD_TICKS = 64;
	localparam logic [5:0]  SHORT_LAST         = 6'(SHORT_PERIOD_TICKS - 1);
	localparam int          SUB_TICKS          = 128;
	localparam logic [6:0]  SUB_LAST           = 7'(SUB_TICKS - 1);

	// ----------------------------------------
	// register byte offsets
	// ----------------------------------------
	localparam logic [5:0]  OFF_CTRL   = 6'h00;
	localparam logic [5:0]  OFF_DUTY0  = 6'h04;
	localparam logic [5:0]  OFF_COARSE = 6'h18;
	localparam logic [5:0]  OFF_FINE   = 6'h1C;
	localparam logic [5:0]  OFF_STATUS = 6'h20;
	localparam logic [5:0]  OFF_PORT   = 6'h24;

	// ----------------------------------------
	// fields and reset values
	// ----------------------------------------
	localparam int          CTRL_SH_SEL_LSB  = 0;
	localparam int          CTRL_SH_POL_BIT  = 5;
	localparam int          CTRL_TUN_POL_BIT = 6;
	localparam int          CTRL_TUN_SEL_BIT = 7;
	localparam logic [7:0]  CTRL_RST         = 8'h40;
	localparam int          STAT_WAIT_BIT    = 0;
	localparam int          STAT_SETTLE_BIT  = 1;
	localparam int          STAT_WORK_LSB    = 8;
	localparam logic [1:0]  RESP_OKAY        = 2'h0;
	localparam logic [1:0]  RESP_SLVERR      = 2'h2;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef struct packed {
		logic       tun_sel;
		logic       tuning_polarity;
		logic       short_pwm_polarity;
		logic [4:0] short_pwm_pin_select;
	} pdt_ctl_s;

	typedef enum logic [2:0] {
		LD_IDLE   = 3'h1,
		LD_WAIT   = 3'h2,
		LD_SETTLE = 3'h4
	} pdt_ld_e;

	typedef struct packed {
		pdt_ctl_s        ctl;
		logic [5:0]      port_out;
		logic [4:0][5:0] short_pwm_duty_value;
		logic [4:0][5:0] duty_lat;
		logic [5:0]      scnt;
		logic [6:0]      coarse_staging_latch;
		logic [6:0]      fine_staging_latch;
		pdt_ld_e         ld;
		logic [13:0]     tuning_working_latch;
		logic [13:0]     active;
		logic [13:0]     tcnt;
		logic [5:0]      pin;
		logic            awready;
		logic            wready;
		logic            aw_got;
		logic            w_got;
		logic [5:0]      waddr;
		logic [31:0]     wdata;
		logic            wlane0;
		logic            bvalid;
		logic [1:0]      bresp;
		logic            arready;
		logic            rvalid;
		logic [31:0]     rdata;
		logic [1:0]      rresp;
	} pdt_state_s;

	typedef struct packed {
		logic [1:0] cnt;
		logic       tick;
	} pdt_div_s;

endpackage

// >>> verilog/pdt_tick_div.sv
// tick divider: one-cycle enable every third clock.
// assumes a synchronous active-low reset on the same clock.
`timescale 1ns/100ps
module pdt_tick_div (
	input  wire logic aclk,
	input  wire logic aresetn,
	output logic      tick
);
	pdt_pkg::pdt_div_s st;
	pdt_pkg::pdt_div_s next_st;

	always_comb begin
		next_st = st;
		next_st.cnt = (st.cnt == pdt_pkg::TICK_LAST) ? 2'h0 : st.cnt + 2'h1;
		next_st.tick = (st.cnt == pdt_pkg::TICK_LAST);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign tick = st.tick;

	a_tick_every_three: assert property (@(posedge aclk) disable iff (!aresetn)
		tick |=> !tick ##1 !tick ##1 tick)
		else $error("tick spacing is not three clocks");
endmodule // pdt_tick_div

// >>> verilog/pdt_top.sv
// five short pulse-width channels and one 14-bit tuning pulse output,
// with an AXI4-Lite register slave.
// assumes aclk at the crystal rate and RC integrators on the pins.
`timescale 1ns/100ps
// Notes on behaviour
// - five 6-bit channels, 64-tick period, one tick is three clocks
// - select bit one routes pulse to pin, zero gives plain port line
// - one polarity bit for all five channels; one inverts them
// - channel active for duty-value ticks out of 64
// - tuning output has 16384 levels from counter, latches, pulse control
// - tuning polarity one is default, zero inverts
// - 14-bit counter per tick; low 7 bits form 128-tick sub-period
// - 7-bit coarse and fine staging latches, 14-bit working latch
// - after a fine write, at next sub-period start both staging latches copy to working
// - new pattern appears one full sub-period after transfer
// - coarse pulse low for coarse+1 ticks each sub-period, then high
// - fine adds one-tick pulses at start of chosen sub-periods
// - each zero fine bit picks a fixed set of sub-periods
// - several zero fine bits give union of their pulses
// - tuning pin is a port line when tuning is not selected
module pdt_top (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [5:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [5:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             tuning_shared_port_line,
	output logic [4:0]       shared_port_line
);
	pdt_pkg::pdt_state_s st;
	pdt_pkg::pdt_state_s next_st;
	logic                tick;
	logic [6:0]          fine_sel;
	logic [4:0]          short_pin_d;
	logic [6:0]          subn;
	logic                sub_start;
	logic                coarse_pulse;
	logic                fine_hit;
	logic                tun_lvl;
	logic                tun_pin_d;

	pdt_tick_div u_div (
		.aclk    (aclk),
		.aresetn (aresetn),
		.tick    (tick)
	);

	// ----------------------------------------
	// pulse generation
	// ----------------------------------------
	assign subn      = st.tcnt[13:7];
	assign sub_start = tick && (st.tcnt[6:0] == pdt_pkg::SUB_LAST);

	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++) begin : g_short
			logic lvl;
			assign lvl = (st.scnt < st.duty_lat[gi]);
			assign short_pin_d[gi] = st.ctl.short_pwm_pin_select[gi]
				? (lvl ^ st.ctl.short_pwm_polarity)
				: st.port_out[gi + 1];
		end
		for (gi = 0; gi < 7; gi++) begin : g_fine
			localparam int          B = 6 - gi;
			localparam logic [6:0]  M = 7'((1 << B) - 1);
			// sub-periods whose lowest set bit is B
			assign fine_sel[gi] = !st.active[gi] && subn[B] && ((subn & M) == 7'h00);
		end
	endgenerate

	// coarse low through tick index coarse, i.e. coarse+1 ticks
	assign coarse_pulse = (st.tcnt[6:0] > st.active[13:7]);
	assign fine_hit     = (st.tcnt[6:0] == 7'h00) && (|fine_sel);
	assign tun_lvl      = coarse_pulse || fine_hit;
	assign tun_pin_d    = st.ctl.tun_sel
		? (st.ctl.tuning_polarity ? tun_lvl : !tun_lvl)
		: st.port_out[0];

	// ----------------------------------------
	// register read mux
	// ----------------------------------------
	function automatic logic [33:0] read_word(input pdt_pkg::pdt_state_s s,
		input logic [5:0] a);
		logic [31:0] d;
		logic [1:0]  r;
		d = 32'h0000_0000;
		r = pdt_pkg::RESP_OKAY;
		case ({a[5:2], 2'h0})
			pdt_pkg::OFF_CTRL:   d[7:0] = s.ctl;
			pdt_pkg::OFF_COARSE: d[6:0] = s.coarse_staging_latch;
			pdt_pkg::OFF_FINE:   d[6:0] = s.fine_staging_latch;
			pdt_pkg::OFF_PORT:   d[5:0] = s.port_out;
			pdt_pkg::OFF_STATUS: begin
				d[pdt_pkg::STAT_WAIT_BIT]   = (s.ld == pdt_pkg::LD_WAIT);
				d[pdt_pkg::STAT_SETTLE_BIT] = (s.ld == pdt_pkg::LD_SETTLE);
				d[pdt_pkg::STAT_WORK_LSB +: 14] = s.tuning_working_latch;
			end
			default: begin
				r = pdt_pkg::RESP_SLVERR;
				for (int i = 0; i < 5; i++) begin
					if ({a[5:2], 2'h0} == 6'(pdt_pkg::OFF_DUTY0 + 4 * i)) begin
						d[5:0] = s.short_pwm_duty_value[i];
						r = pdt_pkg::RESP_OKAY;
					end
				end
			end
		endcase
		return {r, d};
	endfunction

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		logic [5:0] wa;
		logic       wr;
		wa = {st.waddr[5:2], 2'h0};
		wr = st.aw_got && st.w_got && !st.bvalid;
		next_st = st;

		// counters, both move once per tick
		if (tick) begin
			next_st.scnt = st.scnt + 6'h01;
			next_st.tcnt = st.tcnt + 14'h0001;
			// duty sampled only at period wrap, so a write never cuts a pulse
			if (st.scnt == pdt_pkg::SHORT_LAST) begin
				next_st.duty_lat = st.short_pwm_duty_value;
			end
		end

		// working latch loader
		if (sub_start) begin
			next_st.active = st.tuning_working_latch;
		end
		case (st.ld)
			pdt_pkg::LD_IDLE: next_st.ld = pdt_pkg::LD_IDLE;
			pdt_pkg::LD_WAIT: begin
				if (sub_start) begin
					next_st.tuning_working_latch = {st.coarse_staging_latch,
						st.fine_staging_latch};
					next_st.ld = pdt_pkg::LD_SETTLE;
				end
			end
			pdt_pkg::LD_SETTLE: begin
				if (sub_start) begin
					next_st.ld = pdt_pkg::LD_IDLE;
				end
			end
			default: next_st.ld = pdt_pkg::LD_IDLE;
		endcase

		// write channel: address and data taken in either order
		if (s_axi_awvalid && st.awready) begin
			next_st.aw_got = 1'b1;
			next_st.waddr  = s_axi_awaddr;
		end
		if (s_axi_wvalid && st.wready) begin
			next_st.w_got  = 1'b1;
			next_st.wdata  = s_axi_wdata;
			next_st.wlane0 = s_axi_wstrb[0];
		end
		if (st.bvalid && s_axi_bready) begin
			next_st.bvalid = 1'b0;
		end
		if (wr) begin
			next_st.aw_got = 1'b0;
			next_st.w_got  = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp  = pdt_pkg::RESP_OKAY;
			case (wa)
				pdt_pkg::OFF_CTRL: begin
					if (st.wlane0) next_st.ctl = st.wdata[7:0];
				end
				pdt_pkg::OFF_COARSE: begin
					if (st.wlane0) next_st.coarse_staging_latch = st.wdata[6:0];
				end
				pdt_pkg::OFF_FINE: begin
					if (st.wlane0) begin
						next_st.fine_staging_latch = st.wdata[6:0];
						// a write beside a transfer wins: the new value goes next time
						next_st.ld = pdt_pkg::LD_WAIT;
					end
				end
				pdt_pkg::OFF_PORT: begin
					if (st.wlane0) next_st.port_out = st.wdata[5:0];
				end
				pdt_pkg::OFF_STATUS: next_st.bresp = pdt_pkg::RESP_OKAY;
				default: begin
					next_st.bresp = pdt_pkg::RESP_SLVERR;
					for (int i = 0; i < 5; i++) begin
						if (wa == 6'(pdt_pkg::OFF_DUTY0 + 4 * i)) begin
							next_st.bresp = pdt_pkg::RESP_OKAY;
							if (st.wlane0) next_st.short_pwm_duty_value[i] = st.wdata[5:0];
						end
					end
				end
			endcase
		end
		next_st.awready = !next_st.aw_got && !next_st.bvalid;
		next_st.wready  = !next_st.w_got && !next_st.bvalid;

		// read channel
		if (st.rvalid && s_axi_rready) begin
			next_st.rvalid = 1'b0;
		end
		if (s_axi_arvalid && st.arready) begin
			next_st.rvalid = 1'b1;
			{next_st.rresp, next_st.rdata} = read_word(st, s_axi_araddr);
		end
		next_st.arready = !next_st.rvalid;

		next_st.pin = {short_pin_d, tun_pin_d};
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st     <= '0;
			st.ctl <= pdt_pkg::CTRL_RST;
			st.ld  <= pdt_pkg::LD_IDLE;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------
	// outputs, all straight from the state register
	// ----------------------------------------
	assign s_axi_awready           = st.awready;
	assign s_axi_wready            = st.wready;
	assign s_axi_bvalid            = st.bvalid;
	assign s_axi_bresp             = st.bresp;
	assign s_axi_arready           = st.arready;
	assign s_axi_rvalid            = st.rvalid;
	assign s_axi_rdata             = st.rdata;
	assign s_axi_rresp             = st.rresp;
	assign tuning_shared_port_line = st.pin[0];
	assign shared_port_line        = st.pin[5:1];

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_port_line_mode: assert property (
		!st.ctl.short_pwm_pin_select[0] |=> shared_port_line[0] == $past(st.port_out[1]))
		else $error("deselected channel pin does not follow port value");
	a_short_inverted: assert property (
		st.ctl.short_pwm_pin_select[2] && st.ctl.short_pwm_polarity
		&& st.scnt < st.duty_lat[2] |=> !shared_port_line[2])
		else $error("inverted channel not low while active");
	// pin lags state by one clock: last high clock, then low
	// a control write landing here would mask the edge, so skip it
	a_short_duty_end: assert property (
		st.ctl.short_pwm_pin_select[1] && !st.ctl.short_pwm_polarity
		&& tick && st.scnt == st.duty_lat[1] - 6'h01 && st.duty_lat[1] != 6'h00
		&& !(st.aw_got && st.w_got)
		|=> shared_port_line[1] ##1 !shared_port_line[1])
		else $error("channel pulse does not end at duty value");
	a_counter_step: assert property (
		tick |=> st.tcnt == $past(st.tcnt) + 14'h0001)
		else $error("tuning counter did not step on tick");
	a_transfer_edge: assert property (
		sub_start && st.ld == pdt_pkg::LD_WAIT |=> st.tuning_working_latch
		== {$past(st.coarse_staging_latch), $past(st.fine_staging_latch)})
		else $error("working latch not loaded at sub-period start");
	a_pattern_delay: assert property (
		sub_start |=> st.active == $past(st.tuning_working_latch))
		else $error("active pattern not taken one sub-period late");
	a_coarse_high: assert property (
		st.ctl.tun_sel && st.ctl.tuning_polarity && st.tcnt[6:0] > st.active[13:7]
		|=> tuning_shared_port_line)
		else $error("coarse pulse not high after coarse+1 ticks");
	a_fine_mid: assert property (
		st.ctl.tun_sel && st.ctl.tuning_polarity && !st.active[0]
		&& st.tcnt == 14'h2000 |=> tuning_shared_port_line)
		else $error("fine pulse missing in sub-period 64");
	a_tun_inverted: assert property (
		st.ctl.tun_sel && !st.ctl.tuning_polarity && st.tcnt[6:0] == 7'h01
		&& st.active[13:7] != 7'h00 |=> tuning_shared_port_line)
		else $error("inverted tuning output not high in coarse low time");
	a_tuning_port: assert property (
		!st.ctl.tun_sel |=> tuning_shared_port_line == $past(st.port_out[0]))
		else $error("tuning pin does not act as port line");

	c_fine_load: cover property (st.ld == pdt_pkg::LD_WAIT ##[1:400] st.ld == pdt_pkg::LD_SETTLE);
	c_short_pulse: cover property (st.ctl.short_pwm_pin_select[0] && shared_port_line[0]);
	c_fine_pulse: cover property (fine_hit && st.ctl.tun_sel);
	c_bad_addr: cover property (s_axi_bvalid && s_axi_bresp == pdt_pkg::RESP_SLVERR);
endmodule // pdt_top
